// >>> cycle_divider.sv
// Purpose: instruction-cycle tick generator
// Assumes: select fixed at programming time, sampled continuously
// Notes: tick is one sys_clk wide
`timescale 1ns/1ns
`default_nettype none
module cycle_divider (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] cpi_sel,
  output logic            cycle_tick
);
  import pc_seq_pkg::*;
  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] div_last;

  always_comb begin
    unique case (cpi_sel)
      CPI_2:   div_last = DIV_LAST_2;
      CPI_4:   div_last = DIV_LAST_4;
      CPI_8:   div_last = DIV_LAST_8;
      CPI_16:  div_last = DIV_LAST_16;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || div_reg >= div_last) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign cycle_tick = reset_n && (div_reg == div_last);

  a_tick_spacing: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cycle_tick && cpi_sel == CPI_2 && $stable(cpi_sel) |=> !cycle_tick)
    else $error("tick too close");
endmodule : cycle_divider
`default_nettype wire

// >>> decoder_model.sv
// Purpose: decoder stand-in that presents instructions to the sequencer
// Assumes: bench raises go by nonblocking assignment at a falling edge
// Notes: released data lines show inverted values, not the last ones
`timescale 1ns/1ns
`default_nettype none
module decoder_model (
  input  wire logic                sys_clk,
  input  wire logic                go,
  input  wire pc_seq_pkg::pc_op_e  go_op,
  input  wire logic [9:0]          go_target,
  input  wire logic [7:0]          go_acc,
  input  wire logic                instr_done,
  output logic                     instr_valid,
  output var pc_seq_pkg::pc_op_e   op,
  output logic [9:0]               target,
  output logic [7:0]               acc,
  output logic [7:0]               reg_wdata
);
  import pc_seq_pkg::*;
  logic done_seen;
  initial begin
    instr_valid = 1'b0;
    op = OP_NEXT;
    target = 10'h000;
    acc = 8'h00;
    reg_wdata = 8'h00;
    done_seen = 1'b0;
  end
  always @(posedge sys_clk) done_seen <= instr_valid && instr_done;
  ////////////////////////////////////////////////////////////////////////
  // Held until retired; a waiting request reloads with no gap
  always @(negedge sys_clk) begin
    if (go && (!instr_valid || done_seen)) begin
      instr_valid <= 1'b1;
      op <= go_op;
      target <= go_target;
      acc <= go_acc;
      reg_wdata <= go_acc;
    end else if (done_seen) begin
      instr_valid <= 1'b0;
      target <= ~target;
      acc <= ~acc;
      reg_wdata <= ~reg_wdata;
    end
  end
endmodule // decoder_model
`default_nettype wire

// >>> pc_seq_pkg.sv
// Purpose: constants for the program sequencing unit
// Assumes: one instruction-cycle enable derived from sys_clk
package pc_seq_pkg;
  localparam int PC_WIDTH    = 10;
  localparam int PAGE_WORDS  = 1024;
  localparam int INSTR_WIDTH = 13;
  localparam int STACK_DEPTH = 5;
  localparam int LOW_BITS    = 8;
  localparam int DIV_WIDTH   = 4;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 10'h000;
  localparam logic [PC_WIDTH-1:0] PC_ONE   = 10'h001;
  localparam logic [1:0] CPI_2  = 2'h0;
  localparam logic [1:0] CPI_4  = 2'h1;
  localparam logic [1:0] CPI_8  = 2'h2;
  localparam logic [1:0] CPI_16 = 2'h3;
  // Last divider count for each clocks-per-cycle choice
  localparam logic [DIV_WIDTH-1:0] DIV_LAST_2  = 4'h1;
  localparam logic [DIV_WIDTH-1:0] DIV_LAST_4  = 4'h3;
  localparam logic [DIV_WIDTH-1:0] DIV_LAST_8  = 4'h7;
  localparam logic [DIV_WIDTH-1:0] DIV_LAST_16 = 4'hF;
  typedef enum logic [2:0] {
    OP_NEXT, OP_JUMP, OP_CALL, OP_RETURN, OP_REL_ADD, OP_LOW_LOAD,
    OP_REG_WRITE
  } pc_op_e;
endpackage : pc_seq_pkg

// >>> program_counter_stack.sv
// Purpose: program counter with five-level return stack
// Assumes: decoder holds instr_valid and op until instr_done
// Notes: reset_pin_n is asynchronous to sys_clk and is synchronised
`timescale 1ns/1ns
`default_nettype none
module program_counter_stack (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic                         reset_pin_n,
  input  wire logic [1:0]                   cpi_sel,
  input  wire logic                         instr_valid,
  input  wire pc_seq_pkg::pc_op_e           op,
  input  wire logic [pc_seq_pkg::PC_WIDTH-1:0] target,
  input  wire logic [7:0]                   acc,
  input  wire logic [7:0]                   reg_wdata,
  output logic [pc_seq_pkg::PC_WIDTH-1:0]   program_counter,
  output logic                              fetch_en,
  output logic                              instr_done,
  output logic                              extra_cycle,
  output logic                              irq_enable_set
);
  import pc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic       pin_meta_reg;
  logic       pin_sync_reg;
  logic       run;
  logic       cycle_tick;
  logic       extra_reg;
  logic       irq_set_reg;
  logic [PC_WIDTH-1:0] pc_reg;
  logic [PC_WIDTH-1:0] pc_next;
  logic [PC_WIDTH-1:0] pc_plus_one;
  logic [PC_WIDTH-1:0] stack_reg [STACK_DEPTH];
  logic [2:0] sp_reg;
  logic [2:0] sp_top;
  logic       step;
  logic       changes_pc;

  // Two flops, pin is asynchronous
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign run = reset_n && pin_sync_reg;

  cycle_divider u_div (
    .sys_clk    (sys_clk),
    .reset_n    (run),
    .cpi_sel    (cpi_sel),
    .cycle_tick (cycle_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  assign changes_pc = (op != OP_NEXT);
  // Counter changers finish on the second cycle
  assign step = cycle_tick && instr_valid && (!changes_pc || extra_reg);
  assign pc_plus_one = pc_reg + PC_ONE;
  assign sp_top = (sp_reg == 3'h0) ? 3'(STACK_DEPTH - 1) : sp_reg - 3'h1;

  always_ff @(posedge sys_clk) begin
    if (!run) begin
      extra_reg <= 1'b0;
    end else if (cycle_tick && instr_valid && changes_pc) begin
      extra_reg <= !extra_reg;
    end
  end

  always_comb begin
    pc_next = pc_plus_one;
    unique case (op)
      OP_NEXT: pc_next = pc_plus_one;
      OP_JUMP: pc_next = target;
      OP_CALL: pc_next = target;
      OP_RETURN: pc_next = stack_reg[sp_top];
      OP_REL_ADD: pc_next = pc_reg + {2'h0, acc};
      OP_LOW_LOAD: pc_next = {pc_reg[PC_WIDTH-1:LOW_BITS], acc};
      OP_REG_WRITE: pc_next = {pc_reg[PC_WIDTH-1:LOW_BITS], reg_wdata};
      // Unused code treated as a plain step
      default: pc_next = pc_plus_one;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!run) begin
      pc_reg <= PC_RESET;
    end else if (step) begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!run) begin
      sp_reg <= 3'h0;
    end else if (step && op == OP_CALL) begin
      sp_reg <= (sp_reg == 3'(STACK_DEPTH - 1)) ? 3'h0 : sp_reg + 3'h1;
    end else if (step && op == OP_RETURN) begin
      sp_reg <= sp_top;
    end
  end

  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge sys_clk) begin
        if (!run) begin
          stack_reg[i] <= PC_RESET;
        end else if (step && op == OP_CALL && sp_reg == 3'(i)) begin
          stack_reg[i] <= pc_plus_one;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!run) begin
      irq_set_reg <= 1'b0;
    end else begin
      irq_set_reg <= step && op == OP_RETURN && target[0];
    end
  end

  assign program_counter = pc_reg;
  assign fetch_en        = run;
  assign instr_done      = step;
  assign extra_cycle     = extra_reg;
  assign irq_enable_set  = irq_set_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reset clears the counter whatever the decoder presents
  a_reset_clear: assert property (@(posedge sys_clk)
    !reset_n |=> program_counter == PC_RESET)
    else $error("counter not cleared");

  a_pin_clear: assert property (@(posedge sys_clk)
    !run |=> program_counter == PC_RESET)
    else $error("counter not cleared by pin");

  // Two sync flops, so three low samples must stop fetching
  a_pin_hold: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !reset_pin_n [*3] |=> !fetch_en)
    else $error("fetch while pin low");

  a_jump_load: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_JUMP |=> pc_reg == $past(target))
    else $error("jump target wrong");

  a_call_load: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_CALL |=> pc_reg == $past(target))
    else $error("call target wrong");

  // Pushed entry is read back through the new stack top
  a_call_push: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_CALL
    |=> stack_reg[sp_top] == $past(pc_reg) + PC_ONE)
    else $error("call pushed wrong address");

  a_ret_pop: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_RETURN
    |=> pc_reg == $past(stack_reg[sp_top]) && sp_reg == $past(sp_top))
    else $error("return did not pop");

  a_rel_add: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_REL_ADD
    |=> pc_reg == PC_WIDTH'($past(pc_reg) + $past(acc)))
    else $error("relative add wrong");

  a_low_load: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_LOW_LOAD
    |=> pc_reg[PC_WIDTH-1:LOW_BITS] == $past(pc_reg[PC_WIDTH-1:LOW_BITS])
    && pc_reg[LOW_BITS-1:0] == $past(acc))
    else $error("low load wrong");

  a_upper_kept: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_REG_WRITE
    |=> $stable(pc_reg[PC_WIDTH-1:LOW_BITS])
    && pc_reg[LOW_BITS-1:0] == $past(reg_wdata))
    else $error("register write wrong");

  a_next_step: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_NEXT
    |=> pc_reg == $past(pc_reg) + PC_ONE)
    else $error("counter did not advance");

  // First tick of a counter changer only raises the added cycle
  a_extra_cycle: assert property (@(posedge sys_clk)
    disable iff (!run)
    cycle_tick && instr_valid && changes_pc && !extra_reg
    |-> !instr_done ##1 extra_cycle)
    else $error("no extra cycle");

  a_done_single: assert property (@(posedge sys_clk)
    disable iff (!run) instr_done |=> !instr_done)
    else $error("retire pulse too long");

  a_irq_return: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_RETURN && target[0]
    |=> irq_enable_set)
    else $error("enable not set");

  a_irq_quiet: assert property (@(posedge sys_clk)
    disable iff (!run) !(step && op == OP_RETURN && target[0])
    |=> !irq_enable_set)
    else $error("enable set without return");

  a_stack_range: assert property (@(posedge sys_clk)
    disable iff (!run) sp_reg < 3'(STACK_DEPTH))
    else $error("stack pointer out of range");

  // No overflow flag exists, so the wrap itself is the only evidence
  a_stack_wrap: assert property (@(posedge sys_clk)
    disable iff (!run) step && op == OP_CALL
    && sp_reg == 3'(STACK_DEPTH - 1) |=> sp_reg == 3'h0)
    else $error("stack did not wrap");

  c_call: cover property (@(posedge sys_clk) step && op == OP_CALL);
  c_return: cover property (@(posedge sys_clk) step && op == OP_RETURN);
  c_wrap: cover property (@(posedge sys_clk)
    step && op == OP_CALL && sp_reg == 3'(STACK_DEPTH - 1));
  c_rel_add: cover property (@(posedge sys_clk) step && op == OP_REL_ADD);
  c_irq_return: cover property (@(posedge sys_clk) irq_enable_set);
endmodule : program_counter_stack
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the program sequencer
// Assumes: cpi_sel only changes while reset is held
// Notes: relative add counts from the address of the add itself
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pc_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic [1:0] cpi_sel = 2'h0;
  logic go = 1'b0;
  pc_op_e go_op = OP_NEXT;
  logic [9:0] go_target = 10'h000;
  logic [7:0] go_acc = 8'h00;
  logic instr_valid, instr_done, fetch_en, extra_cycle, irq_enable_set;
  pc_op_e op;
  logic [9:0] target, program_counter;
  logic [7:0] acc, reg_wdata;
  int failures = 0;
  int comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  program_counter_stack i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reset_pin_n(reset_pin_n), .cpi_sel(cpi_sel), .instr_valid(instr_valid),
    .op(op), .target(target), .acc(acc), .reg_wdata(reg_wdata),
    .program_counter(program_counter), .fetch_en(fetch_en),
    .instr_done(instr_done), .extra_cycle(extra_cycle),
    .irq_enable_set(irq_enable_set));
  decoder_model i_dec (.sys_clk(sys_clk), .go(go), .go_op(go_op),
    .go_target(go_target), .go_acc(go_acc), .instr_done(instr_done),
    .instr_valid(instr_valid), .op(op), .target(target), .acc(acc),
    .reg_wdata(reg_wdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic [1:0] cpi);
    @(negedge sys_clk);
    reset_n = 1'b0;
    cpi_sel = cpi;
    repeat (3) @(negedge sys_clk);
    check(program_counter, 16'h0000);
    reset_n = 1'b1;
  endtask
  // Bounded wait for retirement, then counter and flags one cycle on
  task automatic wait_done(input logic [9:0] exp, input logic ext_exp,
                           input logic irq_exp);
    int n = 0;
    logic ext = 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
      ext |= (extra_cycle === 1'b1);
    end while (instr_done !== 1'b1 && n < 200);
    if (n >= 200) begin
      failures++;
      end_of_test();
    end else begin
      @(negedge sys_clk);
      check(program_counter, exp);
      check(ext, ext_exp);
      check(irq_enable_set, irq_exp);
      check(fetch_en, 1'b1);
    end
  endtask
  task automatic issue(input pc_op_e o, input logic [9:0] t,
                       input logic [7:0] a, input logic [9:0] exp,
                       input logic irq);
    @(negedge sys_clk);
    go <= 1'b1;
    go_op <= o;
    go_target <= t;
    go_acc <= a;
    @(negedge sys_clk);
    go <= 1'b0;
    wait_done(exp, o != OP_NEXT, irq);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_hold();
    logic bad = 1'b0;
    reset_pin_n = 1'b0;
    go <= 1'b1;
    go_op <= OP_JUMP;
    go_target <= 10'h3FF;
    @(negedge sys_clk);
    go <= 1'b0;
    // Pin passes a two-flop synchroniser first
    repeat (3) @(negedge sys_clk);
    repeat (16) begin
      @(negedge sys_clk);
      bad |= fetch_en !== 1'b0 || instr_done !== 1'b0;
    end
    check(bad, 1'b0);
    reset_pin_n = 1'b1;
    wait_done(10'h3FF, 1'b1, 1'b0);
  endtask
  task automatic t_flow();
    issue(OP_JUMP, 10'h155, 8'h00, 10'h155, 1'b0);
    issue(OP_CALL, 10'h2A0, 8'h00, 10'h2A0, 1'b0);
    issue(OP_RETURN, 10'h000, 8'h00, 10'h156, 1'b0);
    issue(OP_CALL, 10'h300, 8'h00, 10'h300, 1'b0);
    issue(OP_RETURN, 10'h001, 8'h00, 10'h157, 1'b1);
    issue(OP_NEXT, 10'h000, 8'h00, 10'h158, 1'b0);
  endtask
  task automatic t_arith();
    issue(OP_JUMP, 10'h0F0, 8'h00, 10'h0F0, 1'b0);
    issue(OP_REL_ADD, 10'h000, 8'h20, 10'h110, 1'b0);
    issue(OP_JUMP, 10'h3F0, 8'h00, 10'h3F0, 1'b0);
    issue(OP_REL_ADD, 10'h000, 8'h20, 10'h010, 1'b0);
    issue(OP_JUMP, 10'h2F0, 8'h00, 10'h2F0, 1'b0);
    issue(OP_LOW_LOAD, 10'h000, 8'hAB, 10'h2AB, 1'b0);
    issue(OP_REG_WRITE, 10'h000, 8'h5C, 10'h25C, 1'b0);
  endtask
  // Six calls into five levels: first return address is lost
  task automatic t_stack();
    issue(OP_JUMP, 10'h000, 8'h00, 10'h000, 1'b0);
    for (int i = 1; i <= 6; i++) begin
      issue(OP_CALL, 10'(i * 16), 8'h00, 10'(i * 16), 1'b0);
    end
    for (int j = 0; j < 5; j++) begin
      issue(OP_RETURN, 10'h000, 8'h00, 10'(81 - j * 16), 1'b0);
    end
  endtask
  task automatic t_cpi();
    int n;
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      go <= 1'b1;
      go_op <= OP_NEXT;
      wait_done(10'h001, 1'b0, 1'b0);
      n = 1;
      while (instr_done !== 1'b1 && n < 40) begin
        @(negedge sys_clk);
        n++;
      end
      if (n >= 40) begin
        failures++;
        end_of_test();
      end else begin
        check(16'(n), 16'(2 << c));
      end
    end
  endtask
  initial begin
    do_reset(2'h0);
    t_hold();
    $display("hold test done");
    t_flow();
    $display("flow test done");
    t_arith();
    $display("arith test done");
    t_stack();
    $display("stack test done");
    t_cpi();
    $display("cpi test done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
